// >>> hw/ept_page_map.sv
// page cache map entry storage, one write and two read ports
`timescale 1ns/100ps
module ept_page_map #(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned IDX_W = 4,
   parameter int unsigned W     = ept_pkg::ENT_W
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             wrEn,
   input  wire logic [IDX_W-1:0] wrIdx,
   input  wire logic [W-1:0]     wrData,
   input  wire logic [IDX_W-1:0] rdIdxA,
   output logic      [W-1:0]     rdDataA,
   input  wire logic [IDX_W-1:0] rdIdxB,
   output logic      [W-1:0]     rdDataB
);
   import ept_pkg::*;

   logic [W-1:0] mem_q [DEPTH];

   // entries start invalid after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (wrEn) begin
         mem_q[wrIdx] <= wrData;
      end
   end

   // combinational read ports
   assign rdDataA = mem_q[rdIdxA];
   assign rdDataB = mem_q[rdIdxB];
endmodule : ept_page_map

// >>> hw/ept_page_type_change.sv
// page type change leaf engine behind an apb register file
`timescale 1ns/100ps
// Behaviour
// - start only on selector 0x0f; missing feature gives protection fault
// - nonzero privilege level gives a protection fault
// - info address not 64-byte aligned gives protection fault
// - target address not 4-kilobyte aligned gives protection fault
// - target outside protected page cache gives page fault with address
// - reserved info bits or wrong requested type give protection fault
// - first-generation conflict: zero flag, conflict code, stop
// - invalid map entry gives page fault on target
// - second-generation conflict: zero flag, conflict code, entry untouched
// - page fault unless regular, or special type being trimmed
// - pending or modified: zero flag, not-modifiable code, entry untouched
// - owning enclave not initialized gives protection fault
// - success clears restrict bit and permissions, sets modified, writes type
// - completions clear other flags; success clears zero flag, accumulator
// - checks run one per cycle in the fixed order
// - page locked against accept/permission leaves while the leaf runs
// - protected mode: segment limit overrun or lock gives protection fault
// - 64-bit mode: non-canonical operand gives protection fault
module ept_page_type_change #(
   parameter int unsigned PAGES     = 16,
   parameter int unsigned IDX_W     = $clog2(PAGES),
   parameter logic [31:0] CONFL_ERR = 32'h0000_0001,
   parameter logic [31:0] NOMOD_ERR = 32'h0000_0002
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic [ept_pkg::ADDR_W-1:0]  paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ept_pkg::DATA_W-1:0]  pwdata,
   output logic      [ept_pkg::DATA_W-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic                             irq,
   input  wire logic                        gen1Busy,
   input  wire logic                        gen2Busy,
   output logic                             pageLock,
   output logic      [IDX_W-1:0]            pageLockIdx
);
   import ept_pkg::*;

   ept_state_t        st_q;
   ept_state_t        st_d;
   ept_end_t          endK;
   ept_fault_t        fault_q;
   ept_fault_t        fault_d;
   logic [DATA_W-1:0] acc_q;
   logic [DATA_W-1:0] acc_d;
   logic [DATA_W-1:0] faultAddr_q;
   logic [DATA_W-1:0] faultAddr_d;
   logic [DATA_W-1:0] rdData;
   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flags_d;
   logic [INT_W-1:0]  intStat_q;
   logic [INT_W-1:0]  intStat_d;
   logic [INT_W-1:0]  intMask_q;
   logic [INT_W-1:0]  intMask_d;
   logic [IDX_W-1:0]  mapIdx_q;
   logic [IDX_W-1:0]  mapIdx_d;
   logic [ENT_W-1:0]  ent;
   logic [ENT_W-1:0]  mapView;

   // ****************************************
   // apb slave decode
   // ****************************************
   // one wait state: pready rises in the second access cycle
   wire logic idle    = (st_q == ST_IDLE);
   wire logic apbAcc  = psel & penable;
   wire logic ready_d = apbAcc & ~pready;
   wire logic apbDone = apbAcc & pready;
   wire logic addrHit = (paddr[1:0] == 2'h0) && (paddr <= OFF_IMASK);
   wire logic wrEn    = apbDone & pwrite & addrHit;
   wire logic swWr    = wrEn & idle;   // operands frozen while busy
   wire logic rdClr   = apbDone & ~pwrite & (paddr == OFF_ISTAT);
   wire logic [ADDR_W-1:0]   opOff = paddr - OFF_OPS;
   wire logic [OP_SEL_W-1:0] opSel = opOff[OP_SEL_W+1:2];
   wire logic opHit = (paddr >= OFF_OPS) && (paddr < OFF_MIDX);

   // ****************************************
   // operand registers
   // ****************************************
   wire logic [OP_NUM-1:0][DATA_W-1:0] opReg;

   // one word register per operand slot
   for (genvar i = 0; i < OP_NUM; i++) begin : g_op
      logic [DATA_W-1:0] val_q;
      wire logic hit = swWr && (paddr == ADDR_W'(OFF_OPS + 4 * i));
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            val_q <= REG_RST;
         end else if (hit) begin
            val_q <= pwdata;
         end
      end
      assign opReg[i] = val_q;
   end

   // named views of the operand words
   wire logic [DATA_W-1:0] baseLo    = opReg[OP_BLO];
   wire logic [DATA_W-1:0] baseHi    = opReg[OP_BHI];
   wire logic [DATA_W-1:0] cntLo     = opReg[OP_CLO];
   wire logic [DATA_W-1:0] cntHi     = opReg[OP_CHI];
   wire logic [DATA_W-1:0] info      = opReg[OP_INFO];
   wire logic [DATA_W-1:0] env       = opReg[OP_ENV];
   wire logic [DATA_W-1:0] segLim    = opReg[OP_SEG];
   wire logic [DATA_W-1:0] cacheBase = opReg[OP_CBASE];

   // upper address bits must copy the top implemented bit
   function automatic logic isCanon(input logic [DATA_W-1:0] hi);
      isCanon = (hi[DATA_W-1:CANON_BIT] ==
                 {(DATA_W-CANON_BIT){hi[CANON_BIT]}});
   endfunction : isCanon

   // ****************************************
   // check conditions
   // ****************************************
   // leaf is started by a control start write while the accumulator holds the right selector
   wire logic startReq = swWr && (paddr == OFF_CTRL) &&
                         pwdata[CTRL_START] &&
                         (acc_q[LEAF_W-1:0] == LEAF_TYPE_CHANGE);
   wire logic privBad = (env[E_CPL+:2] != 2'h0);
   wire logic featBad = !env[E_FEAT];
   wire logic canonBad = !isCanon(baseHi) || !isCanon(cntHi);
   wire logic limBad   = (baseLo > segLim) || (cntLo > segLim);
   wire logic modeBad  = env[E_MODE64] ? canonBad : limBad;
   wire logic envBad   = privBad | featBad | env[E_LOCK] | modeBad;
   wire logic alignBad = (baseLo[INFO_ALIGN-1:0] != '0) ||
                         (cntLo[PAGE_SHIFT-1:0] != '0);

   // cache residency and page index of the target
   wire logic [DATA_W-1:0] pageOff = cntLo - cacheBase;
   wire logic [IDX_W-1:0]  pageIdx = pageOff[PAGE_SHIFT+:IDX_W];
   wire logic inCache = (cntHi == '0) && (cntLo >= cacheBase) &&
      (pageOff[DATA_W-1:PAGE_SHIFT] <
       (DATA_W-PAGE_SHIFT)'(PAGES));

   // security info type and reserved bits
   wire logic [F_TYPE_MSB:0] reqType = info[F_TYPE_MSB:0];
   wire logic [F_TYPE_MSB:0] curType = ent[F_TYPE_MSB:0];
   wire logic infoBad = (info[DATA_W-1:F_TYPE_MSB+1] != '0) ||
      !((reqType == TYPE_THREAD_CTRL) || (reqType == TYPE_TRIM));

   // allowed type transitions
   wire logic curSpecial = (curType == TYPE_THREAD_CTRL) ||
                           (curType == TYPE_SS_FIRST) ||
                           (curType == TYPE_SS_REST);
   wire logic typeOk = (curType == TYPE_REGULAR) ||
                       (curSpecial && (reqType == TYPE_TRIM));
   wire logic pendBad = ent[F_PEND] | ent[F_MOD];

   // updated entry: valid and pending kept, permissions dropped
   wire logic [ENT_W-1:0] newEnt = {ent[F_VALID], 1'b0, 1'b1,
                                    ent[F_PEND], 3'b000, reqType};

   // ****************************************
   // check sequence
   // ****************************************
   // one check per cycle; any hit ends the leaf
   always_comb begin
      endK = END_NONE;
      case (st_q)
         ST_IDLE:   endK = END_NONE;
         ST_ENV:    if (envBad) endK = END_GP;
         ST_ALIGN:  if (alignBad) endK = END_GP;
         ST_RESID:  if (!inCache) endK = END_PF;
         ST_INFO:   if (infoBad) endK = END_GP;
         ST_GEN1:   if (gen1Busy) endK = END_CONFL;
         ST_VALID:  if (!ent[F_VALID]) endK = END_PF;
         ST_GEN2:   if (gen2Busy) endK = END_CONFL;
         ST_TYPE:   if (!typeOk) endK = END_PF;
         ST_PEND:   if (pendBad) endK = END_NOMOD;
         ST_INIT:   if (!env[E_INIT]) endK = END_GP;
         ST_UPDATE: endK = END_OK;
         default:   endK = END_NONE;
      endcase
   end

   // next step in fixed order, back to idle on any end
   wire logic ending = (endK != END_NONE);
   assign st_d = idle ? (startReq ? ST_ENV : ST_IDLE) :
                 ending ? ST_IDLE :
                 ept_state_t'(st_q + 4'h1);

   // ****************************************
   // results and flags
   // ****************************************
   wire logic completes = (endK == END_OK) || (endK == END_CONFL) ||
                          (endK == END_NOMOD);
   wire logic accWr = swWr && (paddr == OFF_ACC);

   // accumulator takes the return code on completion
   assign acc_d = (endK == END_OK)    ? REG_RST :
                  (endK == END_CONFL) ? CONFL_ERR :
                  (endK == END_NOMOD) ? NOMOD_ERR :
                  accWr ? pwdata : acc_q;
   // faults leave flags; completions clear all but zero flag
   assign flags_d = completes ?
      FLAG_W'({(endK != END_OK)}) : flags_q;
   assign fault_d = (endK == END_GP) ? FLT_GP :
                    (endK == END_PF) ? FLT_PF :
                    completes ? FLT_NONE : fault_q;
   assign faultAddr_d = (endK == END_PF) ? cntLo : faultAddr_q;

   // result word: flags, fault kind, busy
   wire logic [DATA_W-1:0] resWord = {15'h0, !idle, 6'h0, fault_q,
                                      2'h0, flags_q};

   // ****************************************
   // page map
   // ****************************************
   wire logic mapSwWr = swWr && (paddr == OFF_MDATA);
   wire logic upd     = (st_q == ST_UPDATE);
   assign mapIdx_d = (swWr && (paddr == OFF_MIDX)) ?
                     pwdata[IDX_W-1:0] : mapIdx_q;

   // entry storage; the leaf update has the write port while busy
   ept_page_map #(
      .DEPTH (PAGES),
      .IDX_W (IDX_W),
      .W     (ENT_W)
   ) ept_page_map_i (
      .clk     (clk),
      .rst_b   (rst_b),
      .wrEn    (upd | mapSwWr),
      .wrIdx   (upd ? pageIdx : mapIdx_q),
      .wrData  (upd ? newEnt : pwdata[ENT_W-1:0]),
      .rdIdxA  (pageIdx),
      .rdDataA (ent),
      .rdIdxB  (mapIdx_q),
      .rdDataB (mapView)
   );

   // ****************************************
   // interrupts
   // ****************************************
   // sticky events; a read clears only the bits it returned
   wire logic [INT_W-1:0] intSet = {(endK == END_PF),
                                    (endK == END_GP), completes};
   wire logic [INT_W-1:0] intClr = rdClr ? prdata[INT_W-1:0] : '0;
   assign intStat_d = (intStat_q & ~intClr) | intSet;
   assign intMask_d = (wrEn && (paddr == OFF_IMASK)) ?
                      pwdata[INT_W-1:0] : intMask_q;

   // read selection
   always_comb begin
      rdData = '0;
      case (paddr)
         OFF_CTRL:  rdData = DATA_W'(!idle);
         OFF_ACC:   rdData = acc_q;
         OFF_MIDX:  rdData = DATA_W'(mapIdx_q);
         OFF_MDATA: rdData = DATA_W'(mapView);
         OFF_RES:   rdData = resWord;
         OFF_FADDR: rdData = faultAddr_q;
         OFF_ISTAT: rdData = DATA_W'(intStat_q);
         OFF_IMASK: rdData = DATA_W'(intMask_q);
         default:   rdData = opHit ? opReg[opSel] : '0;
      endcase
   end

   // ****************************************
   // flip-flops
   // ****************************************
   // apb answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= ready_d;
         pslverr <= ready_d & ~addrHit;
         prdata  <= (ready_d & ~pwrite & addrHit) ? rdData : '0;
      end
   end

   // leaf state and results
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q        <= ST_IDLE;
         acc_q       <= REG_RST;
         flags_q     <= '0;
         fault_q     <= FLT_NONE;
         faultAddr_q <= REG_RST;
         mapIdx_q    <= '0;
      end else begin
         st_q        <= st_d;
         acc_q       <= acc_d;
         flags_q     <= flags_d;
         fault_q     <= fault_d;
         faultAddr_q <= faultAddr_d;
         mapIdx_q    <= mapIdx_d;
      end
   end

   // page lock, interrupt state and line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intStat_q   <= '0;
         intMask_q   <= '0;
         irq         <= 1'b0;
         pageLock    <= 1'b0;
         pageLockIdx <= '0;
      end else begin
         intStat_q   <= intStat_d;
         intMask_q   <= intMask_d;
         irq         <= |(intStat_d & intMask_d);
         pageLock    <= (st_d != ST_IDLE);
         pageLockIdx <= pageIdx;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_leaf_start:
      assert property ($rose(pageLock) |->
         $past(acc_q[LEAF_W-1:0]) == LEAF_TYPE_CHANGE)
      else $error("leaf started with wrong selector");
   a_priv_gp:
      assert property (st_q == ST_ENV && privBad |=>
         fault_q == FLT_GP && idle)
      else $error("privilege check did not fault");
   a_align_gp:
      assert property (st_q == ST_ALIGN && alignBad |=>
         fault_q == FLT_GP && idle)
      else $error("misaligned operand did not fault");
   a_resid_pf:
      assert property (st_q == ST_RESID && !inCache |=>
         fault_q == FLT_PF && faultAddr_q == $past(cntLo))
      else $error("non-resident target did not page fault");
   a_info_gp:
      assert property (st_q == ST_INFO && infoBad |=>
         fault_q == FLT_GP && idle)
      else $error("bad info did not fault");
   a_gen1_confl:
      assert property (st_q == ST_GEN1 && gen1Busy |=>
         acc_q == CONFL_ERR && flags_q[F_ZF] && idle)
      else $error("first-generation conflict not reported");
   a_valid_pf:
      assert property (st_q == ST_VALID && !ent[F_VALID] |=>
         fault_q == FLT_PF)
      else $error("invalid entry did not page fault");
   a_gen2_keep:
      assert property (st_q == ST_GEN2 && gen2Busy |=>
         acc_q == CONFL_ERR && $stable(ent) && flags_q[F_ZF])
      else $error("second-generation conflict mishandled");
   a_type_pf:
      assert property (st_q == ST_TYPE && !typeOk |=>
         fault_q == FLT_PF && idle)
      else $error("illegal type change did not fault");
   a_nomod_keep:
      assert property (st_q == ST_PEND && pendBad |=>
         acc_q == NOMOD_ERR && flags_q[F_ZF] && $stable(ent))
      else $error("unmodifiable page not reported");
   a_init_gp:
      assert property (st_q == ST_INIT && !env[E_INIT] |=>
         fault_q == FLT_GP && $stable(ent))
      else $error("uninitialized enclave did not fault");
   a_entry_upd:
      assert property (st_q == ST_UPDATE |=> ent[F_MOD] &&
         !ent[F_PR] && ent[F_EXEC:F_READ] == 3'h0 &&
         curType == $past(reqType))
      else $error("entry update wrong");
   a_ok_flags:
      assert property (st_q == ST_UPDATE |=>
         acc_q == REG_RST && flags_q == '0 && fault_q == FLT_NONE)
      else $error("success result wrong");
   a_step_order:
      assert property (st_q == ST_UPDATE |->
         $past(st_q, 1) == ST_INIT && $past(st_q, 2) == ST_PEND)
      else $error("check order broken");
   a_page_lock:
      assert property (!idle |-> pageLock && pageLockIdx == pageIdx)
      else $error("target page not locked while busy");

   c_success:  cover property (st_q == ST_UPDATE);
   c_conflict: cover property (endK == END_CONFL);
   c_nomod:    cover property (endK == END_NOMOD);
   c_pfault:   cover property (st_q == ST_VALID && !ent[F_VALID]);
endmodule : ept_page_type_change

// >>> hw/ept_pkg.sv
// constants, register offsets and types of the page type change leaf
package ept_pkg;
   // ****************************************
   // bus widths and register offsets
   // ****************************************
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam logic [7:0]  OFF_CTRL  = 8'h00;
   localparam logic [7:0]  OFF_ACC   = 8'h04;
   localparam logic [7:0]  OFF_OPS   = 8'h08;
   localparam logic [7:0]  OFF_MIDX  = 8'h28;
   localparam logic [7:0]  OFF_MDATA = 8'h2c;
   localparam logic [7:0]  OFF_RES   = 8'h30;
   localparam logic [7:0]  OFF_FADDR = 8'h34;
   localparam logic [7:0]  OFF_ISTAT = 8'h38;
   localparam logic [7:0]  OFF_IMASK = 8'h3c;
   localparam logic [31:0] REG_RST   = 32'h0000_0000;
   localparam int unsigned CTRL_START = 0;

   // ****************************************
   // operand word indices above OFF_OPS
   // ****************************************
   localparam int unsigned OP_NUM   = 8;
   localparam int unsigned OP_SEL_W = 3;
   localparam int unsigned OP_BLO   = 0;
   localparam int unsigned OP_BHI   = 1;
   localparam int unsigned OP_CLO   = 2;
   localparam int unsigned OP_CHI   = 3;
   localparam int unsigned OP_INFO  = 4;
   localparam int unsigned OP_ENV   = 5;
   localparam int unsigned OP_SEG   = 6;
   localparam int unsigned OP_CBASE = 7;

   // ****************************************
   // leaf selector, page types, alignment
   // ****************************************
   localparam int unsigned LEAF_W           = 8;
   localparam logic [7:0]  LEAF_TYPE_CHANGE = 8'h0f;
   localparam logic [7:0]  TYPE_REGULAR     = 8'h01;
   localparam logic [7:0]  TYPE_THREAD_CTRL = 8'h02;
   localparam logic [7:0]  TYPE_TRIM        = 8'h03;
   localparam logic [7:0]  TYPE_SS_FIRST    = 8'h04;
   localparam logic [7:0]  TYPE_SS_REST     = 8'h05;
   localparam int unsigned INFO_ALIGN       = 6;
   localparam int unsigned PAGE_SHIFT       = 12;
   localparam int unsigned CANON_BIT        = 15;

   // ****************************************
   // map entry, environment, flags, interrupts
   // ****************************************
   localparam int unsigned ENT_W      = 15;
   localparam int unsigned F_TYPE_MSB = 7;
   localparam int unsigned F_READ     = 8;
   localparam int unsigned F_EXEC     = 10;
   localparam int unsigned F_PEND     = 11;
   localparam int unsigned F_MOD      = 12;
   localparam int unsigned F_PR       = 13;
   localparam int unsigned F_VALID    = 14;
   localparam int unsigned E_CPL      = 0;
   localparam int unsigned E_FEAT     = 2;
   localparam int unsigned E_MODE64   = 3;
   localparam int unsigned E_LOCK     = 4;
   localparam int unsigned E_INIT     = 5;
   localparam int unsigned FLAG_W     = 6;
   localparam int unsigned F_ZF       = 0;
   localparam int unsigned INT_W      = 3;

   typedef enum logic [1:0] {
      FLT_NONE = 2'b00,
      FLT_GP   = 2'b01,
      FLT_PF   = 2'b10
   } ept_fault_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_ENV    = 4'b0001,
      ST_ALIGN  = 4'b0010,
      ST_RESID  = 4'b0011,
      ST_INFO   = 4'b0100,
      ST_GEN1   = 4'b0101,
      ST_VALID  = 4'b0110,
      ST_GEN2   = 4'b0111,
      ST_TYPE   = 4'b1000,
      ST_PEND   = 4'b1001,
      ST_INIT   = 4'b1010,
      ST_UPDATE = 4'b1011
   } ept_state_t;

   typedef enum logic [2:0] {
      END_NONE  = 3'b000,
      END_OK    = 3'b001,
      END_CONFL = 3'b010,
      END_NOMOD = 3'b011,
      END_GP    = 3'b100,
      END_PF    = 3'b101
   } ept_end_t;
endpackage : ept_pkg

// >>> testbench/ept_page_type_change_test.sv
// self-checking random bench for the page type change leaf engine
`timescale 1ns/100ps
module ept_page_type_change_test;
   import ept_pkg::*;
   localparam logic [31:0] CB    = 32'h0001_0000;
   localparam logic [31:0] CONF  = 32'h0000_0011;
   localparam logic [31:0] NOMOD = 32'h0000_0022;
   logic        clk = 1'b0, rst_b = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        gen1Busy = 1'b0, gen2Busy = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, r, r2, eAcc;
   logic [31:0] ops [OP_NUM];
   logic        pready, pslverr, irq, pageLock, err, eZf;
   logic [3:0]  pageLockIdx;
   logic [14:0] ent, eEnt;
   logic [4:0]  pg;
   logic [2:0]  mask, eStat;
   logic [1:0]  eFlt;
   int          seed = 89795, miscompares = 0, compares = 0, n;

   always #50 clk = ~clk;

   ept_page_type_change #(.PAGES(16), .CONFL_ERR(CONF), .NOMOD_ERR(NOMOD))
      ept_page_type_change_i (.clk, .rst_b, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq, .gen1Busy, .gen2Busy,
      .pageLock, .pageLockIdx);

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   task automatic hang;
      miscompares++;
      end_of_test();
   endtask : hang

   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20)
         hang();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // expected outcome, checks taken in their fixed order
   function automatic void predict();
      logic [7:0]  q, c;
      logic [5:0]  e;
      logic [31:0] h, lo;
      q = ops[OP_INFO][7:0];
      c = ent[7:0];
      e = ops[OP_ENV][5:0];
      h = ops[OP_CHI];
      lo = ops[OP_CLO];
      eAcc = 32'(LEAF_TYPE_CHANGE);
      eZf = 1'b0;
      eEnt = ent;
      eFlt = FLT_NONE;
      if (e[1:0] != 0 || !e[E_FEAT] || e[E_LOCK] || (e[E_MODE64] ?
          h[31:15] != 17'h0 && h[31:15] != 17'h1ffff :
          ops[OP_BLO] > ops[OP_SEG] || lo > ops[OP_SEG]))
         eFlt = FLT_GP;
      else if (ops[OP_BLO][5:0] != 0 || lo[11:0] != 0)
         eFlt = FLT_GP;
      else if (h != 0 || lo < CB || ((lo - CB) >> 12) >= 16)
         eFlt = FLT_PF;
      else if (ops[OP_INFO][31:8] != 0 ||
               (q != TYPE_THREAD_CTRL && q != TYPE_TRIM))
         eFlt = FLT_GP;
      else if (gen1Busy || (ent[F_VALID] && gen2Busy))
         eAcc = CONF;
      else if (!ent[F_VALID])
         eFlt = FLT_PF;
      else if (!(c == TYPE_REGULAR || ((c == TYPE_THREAD_CTRL ||
               c == TYPE_SS_FIRST || c == TYPE_SS_REST) && q == TYPE_TRIM)))
         eFlt = FLT_PF;
      else if (ent[F_PEND] || ent[F_MOD])
         eAcc = NOMOD;
      else if (!e[E_INIT])
         eFlt = FLT_GP;
      else begin
         eAcc = 32'h0;
         eEnt = {3'b101, ent[F_PEND], 3'b000, q};
      end
      eZf = eFlt == FLT_NONE && eAcc != 0;
      eStat = eFlt == FLT_GP ? 3'b010 : eFlt == FLT_PF ? 3'b100 : 3'b001;
   endfunction : predict

   // random leaves, the first forty mostly legal with chosen corners
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         pg = {&r[6:4], r[3:0]};
         mask = r[31:29];
         ops[OP_BLO] = &r[9:7] ? 32'h44 : 32'h40;
         ops[OP_BHI] = 32'h0;
         ops[OP_CLO] = CB + {15'h0, pg, 12'h0} + (&r[12:10] ? 32'h800 : 32'h0);
         ops[OP_CHI] = &r[15:13] ? 32'h8000 : 32'h0;
         ops[OP_INFO] = {7'h0, &r[18:16], 21'h0, r[21:19]};
         ops[OP_ENV] = {26'h0, ~&r2[1:0], &r2[4:2], r2[5], ~&r2[15:13],
                        (&r2[10:8] ? r2[12:11] : 2'b00)};
         ops[OP_SEG] = &r2[7:6] ? 32'h0 : 32'hffff_ffff;
         ops[OP_CBASE] = CB;
         ent = {|r2[17:16], r2[18], &r2[20:19], &r2[22:21], r2[25:23],
                5'h0, r2[28:26]};
         if (i < 40) begin
            ops[OP_ENV] = i == 15 ? 32'h0c : 32'h2c;
            ops[OP_BLO] = 32'h40;
            ops[OP_CHI] = 32'h0;
            ops[OP_INFO] = 32'(TYPE_THREAD_CTRL) + 32'(r[19]);
            ent[14:11] = {1'b1, r2[18], i == 20, i == 10};
            ent[7:0] = 8'(i % 5 + 1);
            gen1Busy <= i == 7;
            gen2Busy <= i == 9;
         end else begin
            gen1Busy <= &r2[31:29];
            gen2Busy <= &r[24:22];
         end
         foreach (ops[k])
            apb(1'b1, OFF_OPS + 8'(4 * k), ops[k]);
         apb(1'b1, OFF_MIDX, 32'(pg[3:0]));
         apb(1'b1, OFF_MDATA, 32'(ent));
         apb(1'b1, OFF_IMASK, 32'(mask));
         apb(1'b1, OFF_ACC, 32'(LEAF_TYPE_CHANGE));
         apb(1'b1, OFF_CTRL, 32'h1);
         @(posedge clk);
         if (!pg[4])
            chk("lock", 32'({pageLock, pageLockIdx}),
                {27'h0, 1'b1, pg[3:0]});
         predict();
         n = 0;
         do begin
            apb(1'b0, OFF_RES, 32'h0);
            n++;
         end while (rd[16] !== 1'b0 && n < 20);
         if (n >= 20)
            hang();
         chk("fault", 32'(rd[9:8]), 32'(eFlt));
         if (eFlt == FLT_NONE)
            chk("flags", 32'(rd[5:0]), 32'(eZf));
         apb(1'b0, OFF_ACC, 32'h0);
         chk("acc", rd, eAcc);
         apb(1'b0, OFF_FADDR, 32'h0);
         if (eFlt == FLT_PF)
            chk("fault addr", rd, ops[OP_CLO]);
         apb(1'b0, OFF_MDATA, 32'h0);
         chk("entry", rd, 32'(eEnt));
         chk("irq", 32'(irq), 32'(|(eStat & mask)));
         apb(1'b0, OFF_ISTAT, 32'h0);
         chk("status", rd, 32'(eStat));
         repeat (2) @(posedge clk);
         chk("irq clear", 32'(irq), 32'h0);
         $display("leaf %0d done", i);
      end
      end_of_test();
   end
endmodule : ept_page_type_change_test
